// ### design/seep_defines.vh
// Constants for the serial EEPROM command engine.
// Included by the command engine and the bench top, not by the synchroniser or ECC; definitions only.
`ifndef SEEP_DEFINES_VH
`define SEEP_DEFINES_VH

// Opcodes
`define SEEP_OP_WRSTAT   8'h01
`define SEEP_OP_WRITE    8'h02
`define SEEP_OP_READ     8'h03
`define SEEP_OP_WRDIS    8'h04
`define SEEP_OP_RDSTAT   8'h05
`define SEEP_OP_WR_EN    8'h06

// Status register bit positions
`define SEEP_ST_BUSY     0
`define SEEP_ST_WEL      1
`define SEEP_ST_BP0      2
`define SEEP_ST_BP1      3
`define SEEP_ST_LIP      4
`define SEEP_ST_IDSEL    6
`define SEEP_ST_WPEN     7
`define SEEP_ST_WMASK    8'hdc
`define SEEP_ST_RESET    8'h00

// Widths and timing
`define SEEP_ADDR_W      16
`define SEEP_ID_ADDR_W   5
`define SEEP_PAGE_BYTES  64
`define SEEP_TWRITE_NS   5000000
`define SEEP_CLK_NS      10
`define SEEP_TWRITE_CYC  (`SEEP_TWRITE_NS / `SEEP_CLK_NS)

`endif

// ### design/seep_sync.v
// Three-stage input synchroniser for pins from outside core_clk.
// A change counts once the second and third stages agree.
`timescale 1ns/1ps
module seep_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire core_clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule // seep_sync

// ### design/seep_ecc.v
// Byte-level Hamming(12,8) encode and single-bit correcting decode.
// Purely combinational; used beside the storage arrays.
`timescale 1ns/1ps
module seep_ecc (
  input  wire [7:0]  enc_data,
  output wire [3:0]  enc_chk,
  input  wire [7:0]  dec_data,
  input  wire [3:0]  dec_chk,
  output wire [7:0]  dec_fixed,
  output wire        dec_err
);
  function [3:0] chk;
    input [7:0] d;
    begin
      chk[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      chk[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      chk[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      chk[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    end
  endfunction

  wire [3:0] syn = chk(dec_data) ^ dec_chk;
  reg  [7:0] flip;

  // Syndrome gives the Hamming position; map data positions to bits
  always @* begin
    case (syn)
      4'h3:    flip = 8'h01;
      4'h5:    flip = 8'h02;
      4'h6:    flip = 8'h04;
      4'h7:    flip = 8'h08;
      4'h9:    flip = 8'h10;
      4'ha:    flip = 8'h20;
      4'hb:    flip = 8'h40;
      4'hc:    flip = 8'h80;
      default: flip = 8'h00;
    endcase
  end

  assign enc_chk   = chk(enc_data);
  assign dec_fixed = dec_data ^ flip;
  assign dec_err   = (syn != 4'h0);
endmodule // seep_ecc

// ### design/seep_core.v
// Serial EEPROM slave command engine: status read, array and
// identification page read and write, write enable, hold, byte ECC.
// Assumes SPI mode 0/3 pins sampled by core_clk, far faster than sck;
// rst is the power-on detector output.
`timescale 1ns/1ps
`include "seep_defines.vh"

// Function
// - Shift status out after read-status opcode
// - Read-status accepted at any time
// - Status read returns full register while busy
// - Id page uses five address bits, increments
// - Paused: output released, input ignored
// - Power-on detector resets, release gives standby
// - Writes disabled after power-up
// - Write-enable latch cleared after write completes
// - Write starts on select rise, exact count
// - Array commands ignored during internal write
// - Unknown opcode ignored, output stays released
// - Check bits per byte, single-bit correction
// - Page select cleared after read or write
// - Busy bit high during internal write
module seep_core #(
  parameter TWRITE_CYC = `SEEP_TWRITE_CYC,
  parameter ARR_AW     = 14
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       sel_n,
  input  wire       sck,
  input  wire       sdi,
  input  wire       hold_n,
  input  wire       wp_n,
  output reg        sdo,
  output reg        sdo_oe,
  output wire [7:0] status,
  output wire       busy
);
  localparam S_IDLE = 3'd0;
  localparam S_OP   = 3'd1;
  localparam S_ADDR = 3'd2;
  localparam S_RD   = 3'd3;
  localparam S_WR   = 3'd4;
  localparam S_STAT = 3'd5;
  localparam S_WST  = 3'd6;
  localparam S_DONE = 3'd7;
  localparam ARR_N  = 1 << ARR_AW;
  localparam ID_N   = `SEEP_PAGE_BYTES;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire sel_n_s;
  wire sck_s;
  wire sdi_s;
  wire hold_n_s;
  wire wp_n_s;
  seep_sync #(.RST_VAL(1'b1)) u_sel  (.core_clk(core_clk), .rst(rst), .din(sel_n),
                                      .dout(sel_n_s));
  seep_sync #(.RST_VAL(1'b0)) u_sck  (.core_clk(core_clk), .rst(rst), .din(sck),
                                      .dout(sck_s));
  seep_sync #(.RST_VAL(1'b0)) u_sdi  (.core_clk(core_clk), .rst(rst), .din(sdi),
                                      .dout(sdi_s));
  seep_sync #(.RST_VAL(1'b1)) u_hold (.core_clk(core_clk), .rst(rst), .din(hold_n),
                                      .dout(hold_n_s));
  seep_sync #(.RST_VAL(1'b1)) u_wp   (.core_clk(core_clk), .rst(rst), .din(wp_n),
                                      .dout(wp_n_s));

  reg sck_d_reg;
  reg sel_d_reg;
  reg hold_reg;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      hold_reg  <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_n_s;
      // Pause only latched or released while sck low
      if (!sck_s)
        hold_reg <= !hold_n_s;
    end
  end
  wire active  = !sel_n_s && !hold_reg;
  wire rise    = active && sck_s && !sck_d_reg;
  wire fall    = active && !sck_s && sck_d_reg;
  wire sel_end = sel_n_s && !sel_d_reg;

  // ---------------------------------------------------------------
  // Storage with check bits
  // ---------------------------------------------------------------
  reg [11:0] arr_mem [0:ARR_N-1];
  reg [11:0] id_mem  [0:ID_N-1];

  // ---------------------------------------------------------------
  // Command engine state
  // ---------------------------------------------------------------
  reg [2:0]            state_reg;
  reg [2:0]            bit_reg;
  reg [7:0]            shin_reg;
  reg [7:0]            op_reg;
  reg [`SEEP_ADDR_W-1:0] addr_reg;
  reg [4:0]            addr_cnt_reg;
  reg [7:0]            shout_reg;
  reg [7:0]            stat_reg;
  reg [7:0]            wbuf_reg [0:ID_N-1];
  reg [6:0]            wcnt_reg;
  reg                  wok_reg;
  reg [`SEEP_ADDR_W-1:0] wbase_reg;
  reg [7:0]            wstat_reg;
  reg                  wkind_reg;
  reg [31:0]           tw_cnt_reg;
  reg [6:0]            cp_reg;
  reg                  idw_reg;

  wire wel    = stat_reg[`SEEP_ST_WEL];
  wire idsel  = stat_reg[`SEEP_ST_IDSEL];
  assign busy   = (tw_cnt_reg != 32'h0);
  assign status = {stat_reg[7:1], busy};
  wire [7:0] din_byte = {shin_reg[6:0], sdi_s};

  // Read fetch with correction
  wire [ARR_AW-1:0] rd_ai = addr_reg[ARR_AW-1:0];
  wire [5:0]        rd_ii = {1'b0, addr_reg[4:0]};
  wire [11:0]       rd_word = idsel ? id_mem[rd_ii] : arr_mem[rd_ai];
  wire [7:0]        rd_fixed;
  seep_ecc u_ecc (
    .enc_data  (wbuf_reg[cp_reg[5:0]]),
    .enc_chk   (),
    .dec_data  (rd_word[7:0]),
    .dec_chk   (rd_word[11:8]),
    .dec_fixed (rd_fixed),
    .dec_err   ()
  );
  wire [3:0] wr_chk;
  seep_ecc u_ence (
    .enc_data  (wbuf_reg[cp_reg[5:0]]),
    .enc_chk   (wr_chk),
    .dec_data  (8'h00),
    .dec_chk   (4'h0),
    .dec_fixed (),
    .dec_err   ()
  );

  // Block protection: 00 none, 01 top quarter, 10 top half, 11 all
  function prot;
    input [1:0]        bp;
    input [ARR_AW-1:0] a;
    begin
      case (bp)
        2'b01:   prot = (a[ARR_AW-1:ARR_AW-2] == 2'b11);
        2'b10:   prot = a[ARR_AW-1];
        2'b11:   prot = 1'b1;
        default: prot = 1'b0;
      endcase
    end
  endfunction

  wire st_wr_ok = wel && !(stat_reg[`SEEP_ST_WPEN] && !wp_n_s);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      bit_reg      <= 3'd0;
      shin_reg     <= 8'h00;
      op_reg       <= 8'h00;
      addr_reg     <= {`SEEP_ADDR_W{1'b0}};
      addr_cnt_reg <= 5'd0;
      shout_reg    <= 8'h00;
      stat_reg     <= `SEEP_ST_RESET;
      wcnt_reg     <= 7'd0;
      wok_reg      <= 1'b0;
      wbase_reg    <= {`SEEP_ADDR_W{1'b0}};
      wstat_reg    <= 8'h00;
      wkind_reg    <= 1'b0;
      tw_cnt_reg   <= 32'h0;
      cp_reg       <= 7'd0;
      idw_reg      <= 1'b0;
      sdo          <= 1'b0;
      sdo_oe       <= 1'b0;
    end else begin
      // Self-timed write: commit buffer one byte a cycle, then wait
      if (busy) begin
        if (wkind_reg && cp_reg < wcnt_reg) begin
          if (idw_reg)
            id_mem[wbase_reg[4:0] + cp_reg[4:0]] <= {wr_chk, wbuf_reg[cp_reg[5:0]]};
          else
            arr_mem[{wbase_reg[ARR_AW-1:5], wbase_reg[4:0] + cp_reg[4:0]}]
              <= {wr_chk, wbuf_reg[cp_reg[5:0]]};
          cp_reg <= cp_reg + 7'd1;
        end
        tw_cnt_reg <= tw_cnt_reg - 32'h1;
        if (tw_cnt_reg == 32'h1) begin
          stat_reg[`SEEP_ST_WEL] <= 1'b0;
          // Writable bits from the new value, the rest kept; busy and wel end low
          if (!wkind_reg)
            stat_reg <= ((wstat_reg & `SEEP_ST_WMASK) | (stat_reg & ~`SEEP_ST_WMASK))
                        & 8'hfc;
        end
      end

      if (sel_n_s) begin
        state_reg <= S_IDLE;
        bit_reg   <= 3'd0;
        sdo_oe    <= 1'b0;
      end else if (hold_reg) begin
        sdo_oe    <= 1'b0;
      end else if (state_reg == S_IDLE) begin
        state_reg <= S_OP;
        // Keep the byte count while the buffer is still being committed
        if (!busy)
          wcnt_reg <= 7'd0;
        wok_reg   <= 1'b0;
      end

      if (rise) begin
        shin_reg <= din_byte;
        bit_reg  <= bit_reg + 3'd1;
        case (state_reg)
          S_OP: if (bit_reg == 3'd7) begin
            op_reg <= din_byte;
            case (din_byte)
              `SEEP_OP_RDSTAT: begin
                state_reg <= S_STAT;
                shout_reg <= status;
              end
              `SEEP_OP_READ, `SEEP_OP_WRITE: begin
                // Array access while busy is dropped
                state_reg    <= busy ? S_DONE : S_ADDR;
                addr_cnt_reg <= 5'd0;
              end
              `SEEP_OP_WRSTAT: state_reg <= busy ? S_DONE : S_WST;
              `SEEP_OP_WR_EN, `SEEP_OP_WRDIS: state_reg <= S_DONE;
              default:         state_reg <= S_DONE;
            endcase
          end
          S_ADDR: begin
            addr_reg     <= {addr_reg[`SEEP_ADDR_W-2:0], sdi_s};
            addr_cnt_reg <= addr_cnt_reg + 5'd1;
            if (addr_cnt_reg == 5'd15) begin
              bit_reg   <= 3'd0;
              wbase_reg <= {addr_reg[`SEEP_ADDR_W-2:0], sdi_s};
              idw_reg   <= idsel;
              state_reg <= (op_reg == `SEEP_OP_READ) ? S_RD : S_WR;
            end
          end
          S_WR: if (bit_reg == 3'd7) begin
            wbuf_reg[wcnt_reg[5:0]] <= din_byte;
            if (wcnt_reg != 7'd64)
              wcnt_reg <= wcnt_reg + 7'd1;
            wok_reg <= 1'b1;
          end
          S_WST: if (bit_reg == 3'd7) begin
            wstat_reg <= din_byte;
            wok_reg   <= 1'b1;
            state_reg <= S_DONE;
          end
          default: ;
        endcase
      end

      // Output shifts on falling sck; byte loaded once opcode (status) or address (read) done
      if (fall && (state_reg == S_STAT || state_reg == S_RD)) begin
        sdo_oe <= 1'b1;
        if (bit_reg == 3'd0) begin
          sdo       <= (state_reg == S_STAT) ? status[7] : rd_fixed[7];
          shout_reg <= (state_reg == S_STAT) ? {status[6:0], 1'b0}
                                             : {rd_fixed[6:0], 1'b0};
          if (state_reg == S_RD) begin
            if (idsel)
              addr_reg[4:0] <= addr_reg[4:0] + 5'd1;
            else
              addr_reg <= addr_reg + 16'd1;
          end
        end else begin
          sdo       <= shout_reg[7];
          shout_reg <= {shout_reg[6:0], 1'b0};
        end
      end

      // Select rise: commit command; enable and writes need an exact count, disable and read do not
      if (sel_end && !busy) begin
        if (op_reg == `SEEP_OP_WR_EN && state_reg == S_DONE && bit_reg == 3'd0)
          stat_reg[`SEEP_ST_WEL] <= 1'b1;
        else if (op_reg == `SEEP_OP_WRDIS && state_reg == S_DONE)
          stat_reg[`SEEP_ST_WEL] <= 1'b0;
        else if (op_reg == `SEEP_OP_WRSTAT && wok_reg && bit_reg == 3'd0
                 && st_wr_ok) begin
          // Id select and lock cannot both be set at once
          if (wstat_reg[`SEEP_ST_IDSEL] && wstat_reg[`SEEP_ST_LIP])
            stat_reg[`SEEP_ST_WEL] <= 1'b0;
          else begin
            stat_reg[`SEEP_ST_IDSEL] <= wstat_reg[`SEEP_ST_IDSEL];
            wkind_reg  <= 1'b0;
            tw_cnt_reg <= TWRITE_CYC;
          end
        end else if (op_reg == `SEEP_OP_WRITE && state_reg == S_WR && wok_reg
                     && bit_reg == 3'd0 && wel) begin
          stat_reg[`SEEP_ST_IDSEL] <= 1'b0;
          if ((idw_reg && !stat_reg[`SEEP_ST_LIP] && stat_reg[3:2] != 2'b11)
              || (!idw_reg && !prot(stat_reg[3:2], wbase_reg[ARR_AW-1:0]))) begin
            wkind_reg  <= 1'b1;
            cp_reg     <= 7'd0;
            tw_cnt_reg <= TWRITE_CYC;
          end
        end else if (op_reg == `SEEP_OP_READ && state_reg == S_RD)
          stat_reg[`SEEP_ST_IDSEL] <= 1'b0;
      end
    end
  end
endmodule // seep_core

// ### bench/seep_core_monitor.sv
// Checker on the serial EEPROM command engine pins.
// Assumes a bind into seep_core; every pin is seen through core_clk.
`timescale 1ns/1ps
module seep_core_monitor #(
  parameter TWRITE_CYC = 20,
  parameter ARR_AW     = 14
) (
  input wire       core_clk,
  input wire       rst,
  input wire       sel_n,
  input wire       sck,
  input wire       sdi,
  input wire       hold_n,
  input wire       wp_n,
  input wire       sdo,
  input wire       sdo_oe,
  input wire [7:0] status,
  input wire       busy
);
  // Margin covers the select synchroniser
  localparam int TW_MAX = TWRITE_CYC + 8;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst_vals;
    disable iff (1'b0) rst |-> (status == 8'h00 && !busy && !sdo_oe && !sdo);
  endproperty
  property p_bit5;
    status[5] == 1'b0;
  endproperty
  property p_busy_mirror;
    busy == status[0];
  endproperty
  property p_desel_off;
    sel_n [*8] |-> !sdo_oe;
  endproperty
  property p_hold_off;
    !hold_n [*8] |-> !sdo_oe;
  endproperty
  property p_sdo_edge;
    ($changed(sdo) && sdo_oe) |-> !sck;
  endproperty
  property p_busy_start;
    $rose(busy) |-> sel_n;
  endproperty
  property p_busy_min;
    $rose(busy) |-> busy [*8];
  endproperty
  property p_busy_end;
    $rose(busy) |-> ##[1:TW_MAX] !busy;
  endproperty
  property p_wel_clr;
    $fell(busy) |-> ##[0:2] !status[1];
  endproperty
  a_rst_vals:    assert property (p_rst_vals)    else $error("bad reset value");
  a_bit5:        assert property (p_bit5)        else $error("status bit5 set");
  a_busy_mirror: assert property (p_busy_mirror) else $error("busy bit mismatch");
  a_desel_off:   assert property (p_desel_off)   else $error("sdo driven unselected");
  a_hold_off:    assert property (p_hold_off)    else $error("sdo driven in pause");
  a_sdo_edge:    assert property (p_sdo_edge)    else $error("sdo moved with sck high");
  a_busy_start:  assert property (p_busy_start)  else $error("write began selected");
  a_busy_min:    assert property (p_busy_min)    else $error("write too short");
  a_busy_end:    assert property (p_busy_end)    else $error("write never ended");
  a_wel_clr:     assert property (p_wel_clr)     else $error("wel kept after write");
  c_write: cover property ($rose(busy));
  c_read:  cover property ($rose(sdo_oe));
  c_pause: cover property (!hold_n && !sel_n);
endmodule // seep_core_monitor

bind seep_core seep_core_monitor #(.TWRITE_CYC(TWRITE_CYC), .ARR_AW(ARR_AW)) u_mon (
  .core_clk(core_clk), .rst(rst), .sel_n(sel_n), .sck(sck), .sdi(sdi), .hold_n(hold_n),
  .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe), .status(status), .busy(busy));

// ### bench/seep_host.sv
// Host SPI master model, mode 0, sck of 160 ns only inside frames.
// Assumes core_clk of 10 ns; all pins change by NBA on its rise.
`timescale 1ns/1ps
module seep_host (
  input  wire core_clk,
  input  wire sdo,
  input  wire sdo_oe,
  output reg  sel_n,
  output reg  sck,
  output reg  sdi,
  output reg  hold_n
);
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    hold_n = 1'b1;
  end
  task automatic half;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic open_f;
    sel_n <= 1'b0;
    half();
  endtask
  // Released data line shows the inverse of its last bit
  task automatic close_f;
    half();
    sel_n <= 1'b1;
    sdi <= ~sdi;
    half();
  endtask
  task automatic xbits(input [7:0] tx, input integer n, output [7:0] rx, output oe);
    integer i;
    begin
      rx = 8'h00;
      oe = 1'b0;
      for (i = 7; i > 7 - n; i = i - 1) begin
        sdi <= tx[i];
        half();
        sck <= 1'b1;
        rx[i] = sdo;
        oe = oe | sdo_oe;
        half();
        sck <= 1'b0;
      end
    end
  endtask
  // Entered and left with sck low; data toggles meanwhile
  task automatic pause(output oe);
    integer i;
    begin
      hold_n <= 1'b0;
      oe = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        half();
        sdi <= ~sdi;
        if (i > 0) oe = oe | sdo_oe;
      end
      hold_n <= 1'b1;
      half();
    end
  endtask
endmodule // seep_host

// ### bench/tb_top.sv
// Self-checking bench for seep_core driven by the host model.
// Assumes seep_defines.vh on the include path.
`timescale 1ns/1ps
`include "seep_defines.vh"
module tb_top;
  localparam integer TW = 600;
  reg         core_clk;
  reg         rst;
  reg         wp_n;
  wire        sel_n, sck, sdi, hold_n, sdo, sdo_oe, busy;
  wire [7:0]  status;
  integer     miscompares;
  integer     samples_checked;
  integer     i;
  reg  [7:0]  rx;
  reg         oe;
  reg         oe_rd;
  reg  [7:0]  rd [0:3];
  reg  [23:0] rows [0:2];
  seep_core #(.TWRITE_CYC(TW), .ARR_AW(14)) u_dut (.core_clk(core_clk), .rst(rst),
    .sel_n(sel_n), .sck(sck), .sdi(sdi), .hold_n(hold_n), .wp_n(wp_n), .sdo(sdo),
    .sdo_oe(sdo_oe), .status(status), .busy(busy));
  seep_host u_host (.core_clk(core_clk), .sdo(sdo), .sdo_oe(sdo_oe), .sel_n(sel_n),
    .sck(sck), .sdi(sdi), .hold_n(hold_n));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Checks and transfers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp8(input string what, input [7:0] exp, input [7:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input exp, input got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic tx_frame(input logic [7:0] q [$], input integer nrd);
    integer j;
    begin
      u_host.open_f();
      oe_rd = 1'b0;
      for (j = 0; j < q.size(); j = j + 1) u_host.xbits(q[j], 8, rx, oe);
      for (j = 0; j < nrd; j = j + 1) begin
        u_host.xbits(8'h00, 8, rd[j], oe);
        oe_rd = oe_rd | oe;
      end
      u_host.close_f();
    end
  endtask
  task automatic rdstat;
    tx_frame('{`SEEP_OP_RDSTAT}, 1);
  endtask
  task automatic wrstat(input [7:0] v);
    tx_frame('{`SEEP_OP_WR_EN}, 0);
    tx_frame('{`SEEP_OP_WRSTAT, v}, 0);
  endtask
  // Polls busy only, then one more read for the full value
  task automatic wait_idle;
    integer k;
    begin
      rdstat();
      for (k = 0; k < 10 && rd[0][0] !== 1'b0; k = k + 1) rdstat();
      if (rd[0][0] !== 1'b0) begin
        miscompares = miscompares + 1;
        tally_and_finish();
      end
      rdstat();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'b1;
    wp_n = 1'b1;
    rows[0] = {`SEEP_OP_WR_EN, 8'h02, 8'h00};
    rows[1] = {8'ha7, 8'h02, 8'h01};
    rows[2] = {`SEEP_OP_WRDIS, 8'h00, 8'h00};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (i = 0; i < 3; i = i + 1) begin
      tx_frame('{rows[i][23:16]}, rows[i][7:0]);
      if (rows[i][7:0] != 8'h00) cmp1("oe unknown op", 1'b0, oe_rd);
      rdstat();
      cmp8("status row", rows[i][15:8], rd[0]);
      cmp1("oe status", 1'b1, oe_rd);
      $display("row %0d done", i);
    end
    wrstat(8'h40);
    rdstat();
    cmp1("busy polled", 1'b1, rd[0][0]);
    wait_idle();
    cmp8("status after write", 8'h40, rd[0]);
    tx_frame('{`SEEP_OP_WR_EN}, 0);
    tx_frame('{`SEEP_OP_WRITE, 8'h00, 8'h1e, 8'ha5, 8'h5a, 8'h3c}, 0);
    tx_frame('{`SEEP_OP_READ, 8'h00, 8'h00}, 1);
    cmp1("oe read in write", 1'b0, oe_rd);
    wait_idle();
    cmp8("status after page", 8'h00, rd[0]);
    wrstat(8'h40);
    wait_idle();
    tx_frame('{`SEEP_OP_READ, 8'hff, 8'hfe}, 3);
    cmp8("id byte 0", 8'ha5, rd[0]);
    cmp8("id byte 1", 8'h5a, rd[1]);
    cmp8("id byte 2", 8'h3c, rd[2]);
    rdstat();
    cmp8("status after id read", 8'h00, rd[0]);
    $display("id page test done");
    u_host.open_f();
    u_host.xbits(`SEEP_OP_RDSTAT, 8, rx, oe);
    u_host.pause(oe);
    cmp1("oe in pause", 1'b0, oe);
    u_host.xbits(8'h00, 8, rx, oe);
    u_host.close_f();
    cmp8("status over pause", 8'h00, rx);
    $display("pause test done");
    tx_frame('{`SEEP_OP_WR_EN}, 0);
    u_host.open_f();
    u_host.xbits(`SEEP_OP_WRSTAT, 8, rx, oe);
    u_host.xbits(8'h80, 4, rx, oe);
    u_host.close_f();
    cmp1("busy cut write", 1'b0, busy);
    rdstat();
    cmp8("status cut write", 8'h02, rd[0]);
    $display("cut write test done");
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    rdstat();
    cmp8("status after reset", 8'h00, rd[0]);
    $display("reset test done");
    tally_and_finish();
  end
endmodule // tb_top
